// >>> rtl/cjl_params.svh
// Purpose: constants of the jump, load and logic core
// Assumes: included by the core only; the ALU uses cjl_pkg
// Notes: opcodes without a printed value are arbitrary
`ifndef CJL_PARAMS_SVH
`define CJL_PARAMS_SVH
`define CJL_OP_LDACC_IMM 8'hA9
`define CJL_OP_LDACC_ZP  8'hA5
`define CJL_OP_LDIX_IMM  8'hA2
`define CJL_OP_LDIX_ZP   8'hA6
`define CJL_OP_LDIY_IMM  8'hA0
`define CJL_OP_LDIY_ZP   8'hA4
`define CJL_OP_OR_IMM    8'h09
`define CJL_OP_OR_ZP     8'h05
`define CJL_OP_SHR_A     8'h4A
`define CJL_OP_SHR_ZP    8'h46
`define CJL_OP_STIMM     8'h3C
`define CJL_OP_CLT       8'h12
`define CJL_OP_SET       8'h32
`define CJL_OP_JUMP_ABS  8'h4C
`define CJL_OP_JUMP_IND  8'h6C
`define CJL_OP_JUMP_ZPI  8'hB2
`define CJL_OP_CALL_ABS  8'h20
`define CJL_OP_CALL_SPG  8'h22
`define CJL_OP_CALL_ZPI  8'h02
`define CJL_OP_MPY       8'h62
`define CJL_CYC_SHORT    5'h02
`define CJL_CYC_ZP       5'h03
`define CJL_CYC_SHR_ZP   5'h05
`define CJL_CYC_STIMM    5'h04
`define CJL_CYC_JUMP_ABS 5'h03
`define CJL_CYC_JUMP_IND 5'h05
`define CJL_CYC_JUMP_ZPI 5'h04
`define CJL_CYC_CALL_ABS 5'h05
`define CJL_CYC_CALL_SPG 5'h04
`define CJL_CYC_CALL_ZPI 5'h06
`define CJL_CYC_MPY      5'h0F
`define CJL_CYC_T_OR     5'h03
`define CJL_CYC_T_LDACC  5'h02
`define CJL_ZERO_PAGE    8'h00
`define CJL_SPECIAL_PAGE 8'hFF
`define CJL_STACK_PAGE   8'h01
`define CJL_RESET_PC     16'h0000
`define CJL_RESET_SP     8'hFF
`define CJL_RESET_PS     8'h04
`define CJL_PS_N         7
`define CJL_PS_T         5
`define CJL_PS_Z         1
`define CJL_PS_C         0
`endif

// >>> rtl/cjl_pkg.sv
// Purpose: types of the jump, load and logic core
// Assumes: nothing
// Notes: state codes are plain binary
package cjl_pkg;
    typedef enum logic [3:0] {
        CJL_FETCH = 4'h0, CJL_IMM = 4'h1, CJL_OPLO = 4'h2, CJL_OPHI = 4'h3,
        CJL_PLO = 4'h4, CJL_PHI = 4'h5, CJL_RDMEM = 4'h6, CJL_RDX = 4'h7,
        CJL_EXEC = 4'h8, CJL_WRITE = 4'h9, CJL_PUSHH = 4'hA,
        CJL_PUSHL = 4'hB, CJL_PAD = 4'hC
    } cjl_state_t;
    typedef enum logic [1:0] {
        CJL_ALU_PASS = 2'h0, CJL_ALU_OR = 2'h1, CJL_ALU_SHR = 2'h2,
        CJL_ALU_MPY = 2'h3
    } cjl_alu_op_t;
endpackage : cjl_pkg

// >>> rtl/cjl_alu_if.sv
// Purpose: operands and results between core and ALU
// Assumes: purely combinational ALU
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface cjl_alu_if;
    import cjl_pkg::*;
    cjl_alu_op_t op;
    logic [7:0]  a_in;
    logic [7:0]  m_in;
    logic [7:0]  res;
    logic [7:0]  res_hi;
    logic        carry;
    modport core (output op, output a_in, output m_in,
                  input res, input res_hi, input carry);
    modport alu  (input op, input a_in, input m_in,
                  output res, output res_hi, output carry);
endinterface : cjl_alu_if
`default_nettype wire

// >>> rtl/cjl_alu.sv
// Purpose: OR, right shift, pass and multiply for the core
// Assumes: operands stable within the cycle
// Notes: no flags kept here; the core latches them
`timescale 1ns/1ps
`default_nettype none
module cjl_alu (
    cjl_alu_if.alu bus
);
    import cjl_pkg::*;
    wire logic [15:0] product;
    wire logic [7:0]  or_val;
    wire logic [7:0]  shr_val;
    assign product = bus.a_in * bus.m_in; // RULE11
    assign or_val  = bus.a_in | bus.m_in; // RULE12
    assign shr_val = {1'b0, bus.m_in[7:1]}; // RULE10
    assign bus.res = (bus.op == CJL_ALU_OR)  ? or_val :
                     (bus.op == CJL_ALU_SHR) ? shr_val :
                     (bus.op == CJL_ALU_MPY) ? product[7:0] : bus.m_in;
    assign bus.res_hi = product[15:8];
    assign bus.carry  = bus.m_in[0]; // RULE10
endmodule : cjl_alu
`default_nettype wire

// >>> rtl/cjl_core.sv
// Purpose: jump, call, load, shift, OR and multiply sequencing
// Assumes: memory answers a read in the same cycle as the address
// Notes: one memory access per cycle, short instructions padded
//
// Summary of operation
// (RULE1) Absolute jump loads PC low and high from operand bytes.
// (RULE2) Indirect jump reads PC from pointer and pointer plus one; zero-page form uses page 00.
// (RULE3) Call pushes PC high, decrements, pushes low, decrements, then jumps.
// (RULE4) Special-page call forces PC high to FF; indirect call reads page 00.
// (RULE5) Accumulator load with T clear copies memory into A; A9 and A5.
// (RULE6) Accumulator load with T set writes operand to M(X), A unchanged.
// (RULE7) Immediate-to-memory store: zero-page target, 4 cycles, 3 bytes.
// (RULE8) X load copies operand into X; A2 and A6.
// (RULE9) Y load copies operand into Y; A0 and A4.
// (RULE10) Right shift: old bit 0 to carry, bit 7 cleared; 4A and 46.
// (RULE11) Multiply A by M(zz+X); high byte pushed, low byte in A.
// (RULE12) OR with T clear puts A OR memory into A; 09 and 05.
// (RULE13) OR with T set writes M(X) OR operand back to M(X).
// (RULE14) Status bit T selects X mode; a clear instruction resets it.
// (RULE15) OR takes 3 more cycles when T is set.
// (RULE16) Accumulator load takes 2 more cycles when T is set.
// (RULE17) Loads, OR and shift set N and Z; shift also sets carry.
`timescale 1ns/1ps
`default_nettype none
`include "cjl_params.svh"
module cjl_core (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Memory port
    output logic [15:0]      mem_addr,
    output logic             mem_re,
    output logic             mem_we,
    output logic [7:0]       mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    // Register state
    output logic [15:0]      pc,
    output logic [7:0]       a,
    output logic [7:0]       x,
    output logic [7:0]       y,
    output logic [7:0]       s,
    output logic [7:0]       p,
    output logic             fetching
);
    import cjl_pkg::*;
    cjl_state_t  state, next_state;
    logic [7:0]  ir, oplo, ophi, tmp;
    logic [4:0]  cyc;
    logic [15:0] next_pc;
    logic [7:0]  next_a, next_x, next_y, next_s, next_p;
    logic [7:0]  next_ir, next_oplo, next_ophi, next_tmp;
    logic [4:0]  next_cyc;
    cjl_alu_if   alu_bus ();

    cjl_alu u_alu (
        .bus (alu_bus)
    );

    function automatic logic [4:0] cyc_count(input logic [7:0] o, input logic t);
        case (o)
            `CJL_OP_LDACC_IMM: cyc_count = t ? `CJL_CYC_SHORT + `CJL_CYC_T_LDACC : `CJL_CYC_SHORT;
            `CJL_OP_LDACC_ZP:  cyc_count = t ? `CJL_CYC_ZP + `CJL_CYC_T_LDACC : `CJL_CYC_ZP;
            `CJL_OP_OR_IMM:    cyc_count = t ? `CJL_CYC_SHORT + `CJL_CYC_T_OR : `CJL_CYC_SHORT;
            `CJL_OP_OR_ZP:     cyc_count = t ? `CJL_CYC_ZP + `CJL_CYC_T_OR : `CJL_CYC_ZP;
            `CJL_OP_LDIX_ZP, `CJL_OP_LDIY_ZP: cyc_count = `CJL_CYC_ZP;
            `CJL_OP_SHR_ZP:    cyc_count = `CJL_CYC_SHR_ZP;
            `CJL_OP_STIMM:     cyc_count = `CJL_CYC_STIMM;
            `CJL_OP_JUMP_ABS:  cyc_count = `CJL_CYC_JUMP_ABS;
            `CJL_OP_JUMP_IND:  cyc_count = `CJL_CYC_JUMP_IND;
            `CJL_OP_JUMP_ZPI:  cyc_count = `CJL_CYC_JUMP_ZPI;
            `CJL_OP_CALL_ABS:  cyc_count = `CJL_CYC_CALL_ABS;
            `CJL_OP_CALL_SPG:  cyc_count = `CJL_CYC_CALL_SPG;
            `CJL_OP_CALL_ZPI:  cyc_count = `CJL_CYC_CALL_ZPI;
            `CJL_OP_MPY:       cyc_count = `CJL_CYC_MPY;
            default:         cyc_count = `CJL_CYC_SHORT;
        endcase
    endfunction : cyc_count

    // Decode; during fetch the opcode is still on the read bus
    wire logic [7:0] op     = (state == CJL_FETCH) ? mem_rdata : ir;
    wire logic is_ldacc = (op == `CJL_OP_LDACC_IMM) || (op == `CJL_OP_LDACC_ZP);
    wire logic is_ldix = (op == `CJL_OP_LDIX_IMM) || (op == `CJL_OP_LDIX_ZP);
    wire logic is_ldiy = (op == `CJL_OP_LDIY_IMM) || (op == `CJL_OP_LDIY_ZP);
    wire logic is_or   = (op == `CJL_OP_OR_IMM) || (op == `CJL_OP_OR_ZP);
    wire logic imm     = (op == `CJL_OP_LDACC_IMM) || (op == `CJL_OP_LDIX_IMM) ||
                         (op == `CJL_OP_LDIY_IMM) || (op == `CJL_OP_OR_IMM);
    wire logic shr_a   = (op == `CJL_OP_SHR_A);
    wire logic shr_z   = (op == `CJL_OP_SHR_ZP);
    wire logic st_imm  = (op == `CJL_OP_STIMM);
    wire logic mpy     = (op == `CJL_OP_MPY);
    wire logic jump_a  = (op == `CJL_OP_JUMP_ABS);
    wire logic jump_i  = (op == `CJL_OP_JUMP_IND);
    wire logic jump_zi = (op == `CJL_OP_JUMP_ZPI);
    wire logic call_a  = (op == `CJL_OP_CALL_ABS);
    wire logic call_spg = (op == `CJL_OP_CALL_SPG);
    wire logic call_zi = (op == `CJL_OP_CALL_ZPI);
    wire logic is_jump = jump_a || jump_i || jump_zi;
    wire logic is_call = call_a || call_spg || call_zi;
    wire logic zpr     = !imm && (is_ldacc || is_ldix || is_ldiy || is_or || shr_z);
    wire logic tmode   = p[`CJL_PS_T] && (is_ldacc || is_or); // RULE14
    wire logic fin     = (cyc == cyc_count(op, p[`CJL_PS_T]) - 5'h01); // RULE15 RULE16
    wire cjl_state_t done_nxt = fin ? CJL_FETCH : CJL_PAD;
    wire logic rd_st   = (state == CJL_IMM) || (state == CJL_RDMEM);
    wire logic apply_now = rd_st && !st_imm && !tmode && !shr_z && !mpy;
    wire logic nz_now  = apply_now || (rd_st && tmode && is_ldacc) ||
                         (state == CJL_RDX) || (state == CJL_EXEC && (shr_a || shr_z));
    wire logic [7:0] ptr_hi = jump_i ? ophi : `CJL_ZERO_PAGE; // RULE2 RULE4
    wire logic [7:0] zp_lo  = mpy ? oplo + x : oplo; // RULE11

    assign fetching      = (state == CJL_FETCH);
    assign alu_bus.op    = is_or ? CJL_ALU_OR : (shr_a || shr_z) ? CJL_ALU_SHR :
                           mpy ? CJL_ALU_MPY : CJL_ALU_PASS;
    assign alu_bus.a_in  = (state == CJL_RDX) ? tmp : a;
    assign alu_bus.m_in  = (state == CJL_EXEC) ? (shr_a ? a : tmp) : mem_rdata;

    // Memory addressing; read data must be valid in the same cycle
    assign mem_re = (state <= CJL_RDX);
    assign mem_we = (state == CJL_WRITE) || (state == CJL_PUSHH) || (state == CJL_PUSHL);
    assign mem_wdata = (state == CJL_PUSHH) ? pc[15:8] : // RULE3
                       (state == CJL_PUSHL) ? pc[7:0] : tmp;
    assign mem_addr =
        (state == CJL_PLO)   ? {ptr_hi, oplo} :
        (state == CJL_PHI)   ? {ptr_hi, oplo + 8'h01} : // RULE2
        (state == CJL_RDMEM) ? {`CJL_ZERO_PAGE, zp_lo} :
        (state == CJL_RDX)   ? {`CJL_ZERO_PAGE, x} : // RULE13
        (state == CJL_PUSHH || state == CJL_PUSHL) ? {`CJL_STACK_PAGE, s} :
        (state == CJL_WRITE) ? (mpy ? {`CJL_STACK_PAGE, s} : // RULE11
                                (st_imm || shr_z) ? {`CJL_ZERO_PAGE, oplo} : // RULE7
                                {`CJL_ZERO_PAGE, x}) : pc; // RULE6

    always_comb begin
        next_state = state;
        next_pc = pc;
        next_a = a;
        next_x = x;
        next_y = y;
        next_s = s;
        next_p = p;
        next_ir = ir;
        next_oplo = oplo;
        next_ophi = ophi;
        next_tmp = tmp;
        next_cyc = cyc + 5'h01;
        case (state)
            CJL_FETCH: begin
                next_ir = mem_rdata;
                next_pc = pc + 16'h0001;
                next_cyc = 5'h01;
                if (imm || st_imm) next_state = CJL_IMM;
                else if (zpr || is_jump || is_call || mpy) next_state = CJL_OPLO;
                else next_state = CJL_EXEC;
            end
            CJL_IMM: begin
                next_pc = pc + 16'h0001;
                next_tmp = mem_rdata;
                if (st_imm) next_state = CJL_OPLO; // RULE7
                else if (tmode) next_state = is_or ? CJL_RDX : CJL_WRITE; // RULE6
                else next_state = done_nxt;
            end
            CJL_OPLO: begin
                next_pc = pc + 16'h0001;
                next_oplo = mem_rdata; // RULE1
                if (jump_a || call_a || jump_i) next_state = CJL_OPHI;
                else if (st_imm) next_state = CJL_WRITE;
                else if (jump_zi || call_zi) next_state = CJL_PLO;
                else if (call_spg) begin
                    next_ophi = `CJL_SPECIAL_PAGE; // RULE4
                    next_state = CJL_PUSHH;
                end
                else next_state = CJL_RDMEM;
            end
            CJL_OPHI: begin
                next_pc = pc + 16'h0001;
                next_ophi = mem_rdata;
                if (jump_a) begin
                    next_pc = {mem_rdata, oplo}; // RULE1
                    next_state = done_nxt;
                end
                else if (jump_i) next_state = CJL_PLO;
                else next_state = CJL_PUSHH;
            end
            CJL_PLO: begin
                next_tmp = mem_rdata;
                next_state = CJL_PHI;
            end
            CJL_PHI: begin
                if (is_jump) begin
                    next_pc = {mem_rdata, tmp}; // RULE2
                    next_state = done_nxt;
                end
                else begin
                    next_ophi = mem_rdata; // RULE4
                    next_oplo = tmp;
                    next_state = CJL_PUSHH;
                end
            end
            CJL_RDMEM: begin
                next_tmp = mem_rdata;
                if (shr_z || mpy) next_state = CJL_EXEC;
                else if (tmode) next_state = is_or ? CJL_RDX : CJL_WRITE;
                else next_state = done_nxt;
            end
            CJL_RDX: begin
                next_tmp = alu_bus.res; // RULE13
                next_state = CJL_WRITE;
            end
            CJL_EXEC: begin
                next_state = done_nxt;
                if (shr_a) next_a = alu_bus.res; // RULE10
                else if (shr_z) begin
                    next_tmp = alu_bus.res;
                    next_state = CJL_WRITE;
                end
                else if (mpy) begin
                    next_a = alu_bus.res; // RULE11
                    next_tmp = alu_bus.res_hi;
                    next_state = CJL_WRITE;
                end
                else if (op == `CJL_OP_CLT) next_p[`CJL_PS_T] = 1'b0; // RULE14
                else if (op == `CJL_OP_SET) next_p[`CJL_PS_T] = 1'b1;
            end
            CJL_WRITE: begin
                if (mpy) next_s = s - 8'h01; // RULE11
                next_state = done_nxt;
            end
            CJL_PUSHH: begin
                next_s = s - 8'h01; // RULE3
                next_state = CJL_PUSHL;
            end
            CJL_PUSHL: begin
                next_s = s - 8'h01; // RULE3
                next_pc = {ophi, oplo};
                next_state = done_nxt;
            end
            CJL_PAD: next_state = done_nxt;
            default: next_state = CJL_FETCH;
        endcase
        if (apply_now) begin
            if (is_ldacc || is_or) next_a = alu_bus.res; // RULE5 RULE12
            if (is_ldix) next_x = alu_bus.res; // RULE8
            if (is_ldiy) next_y = alu_bus.res; // RULE9
        end
        if (nz_now) begin
            next_p[`CJL_PS_N] = alu_bus.res[7]; // RULE17
            next_p[`CJL_PS_Z] = (alu_bus.res == 8'h00);
        end
        if (state == CJL_EXEC && (shr_a || shr_z)) next_p[`CJL_PS_C] = alu_bus.carry; // RULE17
    end

    // Registers; the reset PC is fixed since no vector fetch is modelled
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= CJL_FETCH;
            pc <= `CJL_RESET_PC;
            {a, x, y, ir, oplo, ophi, tmp} <= {7{8'h00}};
            s <= `CJL_RESET_SP;
            p <= `CJL_RESET_PS;
            cyc <= 5'h00;
        end
        else begin
            state <= next_state;
            pc <= next_pc;
            {a, x, y, ir, oplo, ophi, tmp} <= {next_a, next_x, next_y, next_ir,
                                               next_oplo, next_ophi, next_tmp};
            s <= next_s;
            p <= next_p;
            cyc <= next_cyc;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire logic a_lsb = a[0];
    AST_JUMP_ABS: assert property ((state == CJL_OPHI && jump_a) |=> // RULE1
        pc == {$past(mem_rdata), $past(oplo)}) else $error("absolute jump target wrong");
    AST_PTR_PAGE: assert property (((state == CJL_PLO || state == CJL_PHI) && !jump_i) |-> // RULE2
        mem_addr[15:8] == `CJL_ZERO_PAGE) else $error("pointer not in page 00");
    AST_CALL_PUSH: assert property (state == CJL_PUSHH |-> // RULE3
        (mem_we && mem_addr == {`CJL_STACK_PAGE, s} && mem_wdata == pc[15:8]) ##1
        (state == CJL_PUSHL && s == $past(s) - 8'h01 && mem_wdata == pc[7:0]) ##1
        (pc == {$past(ophi), $past(oplo)})) else $error("call push order wrong");
    AST_SPG_PAGE: assert property ((state == CJL_OPLO && call_spg) |=> // RULE4
        ophi == `CJL_SPECIAL_PAGE) else $error("special page high byte wrong");
    AST_LDACC_IMM: assert property ((state == CJL_IMM && is_ldacc && !tmode) |=> // RULE5
        a == $past(mem_rdata)) else $error("accumulator load wrong");
    AST_LDACC_TMODE: assert property ((state == CJL_WRITE && is_ldacc) |-> // RULE6
        mem_addr == {`CJL_ZERO_PAGE, x} ##1 a == $past(a)) else $error("X mode load wrong");
    AST_STIMM_LEN: assert property ((state == CJL_FETCH && st_imm) |-> ##4 // RULE7
        (state == CJL_FETCH && pc == $past(pc, 4) + 16'h0003)) else $error("store length wrong");
    AST_LDIX: assert property ((state == CJL_IMM && is_ldix) |=> // RULE8
        x == $past(mem_rdata)) else $error("X load wrong");
    AST_LDIY_FLAGS: assert property ((state == CJL_IMM && is_ldiy) |=> // RULE9
        (y == $past(mem_rdata) && p[`CJL_PS_Z] == (y == 8'h00))) else $error("Y load wrong");
    AST_SHR: assert property ((state == CJL_EXEC && shr_a) |=> // RULE10
        (a == ($past(a) >> 1) && p[`CJL_PS_C] == $past(a_lsb))) else $error("shift wrong");
    AST_MPY_PUSH: assert property ((state == CJL_WRITE && mpy) |-> // RULE11
        (mem_we && mem_addr == {`CJL_STACK_PAGE, s}) ##1 s == $past(s) - 8'h01)
        else $error("multiply push wrong");
    AST_OR: assert property ((state == CJL_IMM && is_or && !tmode) |=> // RULE12
        a == ($past(a) | $past(mem_rdata))) else $error("OR result wrong");
    AST_OR_TMODE: assert property (state == CJL_RDX |=> // RULE13
        (mem_we && mem_wdata == ($past(tmp) | $past(mem_rdata)))) else $error("X mode OR wrong");
    AST_CLT: assert property ((state == CJL_EXEC && op == `CJL_OP_CLT) |=> // RULE14
        !p[`CJL_PS_T]) else $error("T not cleared");
    AST_OR_T_LEN: assert property ((state == CJL_FETCH && is_or && imm && p[`CJL_PS_T]) |-> // RULE15
        ##1 (state != CJL_FETCH) [*4] ##1 state == CJL_FETCH) else $error("X mode OR length");
    AST_LDACC_T_LEN: assert property ((state == CJL_FETCH && is_ldacc && imm && p[`CJL_PS_T]) |-> // RULE16
        ##1 (state != CJL_FETCH) [*3] ##1 state == CJL_FETCH) else $error("X mode load length");
    CVR_CALL_ZPI: cover property (state == CJL_PHI && call_zi);
    CVR_OR_TMODE: cover property (state == CJL_RDX);
    CVR_MPY: cover property (state == CJL_WRITE && mpy);
    CVR_STIMM: cover property (state == CJL_WRITE && st_imm);
endmodule : cjl_core
`default_nettype wire

// >>> verification/cpu_jump_load_logic_ops_bench.sv
// Purpose: self-checking bench for the jump, load and logic core
// Assumes: memory is modelled here and answers in the same cycle
// Notes: one short program per table row; X mode and multiply by hand
`timescale 1ns/1ps
`default_nettype none
module cpu_jump_load_logic_ops_bench;
    typedef struct {
        logic [7:0]  op, b1, b2, n, sel;
        logic [15:0] v, ma;
        logic [7:0]  mv, pv, sv;
    } cjl_row_t;

    logic        sys_clk  = 1'b0;
    logic        nrst     = 1'b0;
    logic [15:0] mem_addr;
    logic [15:0] pc;
    logic        mem_re;
    logic        mem_we;
    logic        fetching;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;
    logic [7:0]  a, x, y, s, p;
    logic [7:0]  mem [0:65535];
    logic [7:0]  hand [13];
    logic [15:0] got;
    int          n_errors = 0;
    int          n_tests  = 0;
    int          cyc;
    cjl_row_t    rows [16];

    always #5 sys_clk = ~sys_clk;

    // Zero-latency memory, as the core expects
    assign mem_rdata = mem[mem_addr];
    always @(posedge sys_clk) begin
        if (mem_we === 1'b1) begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    cjl_core uut (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .mem_addr  (mem_addr),
        .mem_re    (mem_re),
        .mem_we    (mem_we),
        .mem_wdata (mem_wdata),
        .mem_rdata (mem_rdata),
        .pc        (pc),
        .a         (a),
        .x         (x),
        .y         (y),
        .s         (s),
        .p         (p),
        .fetching  (fetching)
    );

    task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
        n_tests++;
        if (got_v !== exp_v) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask : chk

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // Wipe memory under reset so no row sees leftovers of the last
    task automatic prep();
        @(posedge sys_clk);
        nrst <= 1'b0;
        foreach (mem[i]) mem[i] = 8'h00;
        mem[16'h0010] = 8'h81;
        mem[16'h0012] = 8'h78;
        mem[16'h0013] = 8'h56;
        mem[16'h0040] = 8'h90;
        @(posedge sys_clk);
    endtask : prep

    // Release reset, count cycles until k instructions have completed
    task automatic run(input int k);
        int seen;
        seen = 0;
        cyc = 0;
        nrst <= 1'b1;
        @(negedge sys_clk);
        while (seen < k) begin
            @(negedge sys_clk);
            cyc++;
            if (fetching === 1'b1) begin
                seen++;
            end
            if (cyc > 200) begin
                n_errors++;
                $display("mismatch at %0t: got %h expected %h", $time, cyc, k);
                results();
            end
        end
    endtask : run

    initial begin
        rows = '{
            '{8'hA9, 8'h81, 8'h00, 8'h02, 8'h00, 16'h0081, 16'h0010, 8'h81, 8'h84, 8'hFF},
            '{8'hA5, 8'h10, 8'h00, 8'h03, 8'h00, 16'h0081, 16'h0010, 8'h81, 8'h84, 8'hFF},
            '{8'hA2, 8'h00, 8'h00, 8'h02, 8'h01, 16'h0000, 16'h0010, 8'h81, 8'h06, 8'hFF},
            '{8'hA6, 8'h10, 8'h00, 8'h03, 8'h01, 16'h0081, 16'h0010, 8'h81, 8'h84, 8'hFF},
            '{8'hA0, 8'h7F, 8'h00, 8'h02, 8'h02, 16'h007F, 16'h0010, 8'h81, 8'h04, 8'hFF},
            '{8'hA4, 8'h11, 8'h00, 8'h03, 8'h02, 16'h0000, 16'h0010, 8'h81, 8'h06, 8'hFF},
            '{8'h09, 8'h81, 8'h00, 8'h02, 8'h00, 16'h0081, 16'h0010, 8'h81, 8'h84, 8'hFF},
            '{8'h05, 8'h11, 8'h00, 8'h03, 8'h00, 16'h0000, 16'h0010, 8'h81, 8'h06, 8'hFF},
            '{8'h46, 8'h10, 8'h00, 8'h05, 8'h00, 16'h0000, 16'h0010, 8'h40, 8'h05, 8'hFF},
            '{8'h3C, 8'h5A, 8'h20, 8'h04, 8'h03, 16'h0003, 16'h0020, 8'h5A, 8'h04, 8'hFF},
            '{8'h4C, 8'h34, 8'h12, 8'h03, 8'h03, 16'h1234, 16'h0010, 8'h81, 8'h04, 8'hFF},
            '{8'h6C, 8'h12, 8'h00, 8'h05, 8'h03, 16'h5678, 16'h0010, 8'h81, 8'h04, 8'hFF},
            '{8'hB2, 8'h12, 8'h00, 8'h04, 8'h03, 16'h5678, 16'h0010, 8'h81, 8'h04, 8'hFF},
            '{8'h20, 8'h34, 8'h12, 8'h05, 8'h03, 16'h1234, 16'h01FE, 8'h03, 8'h04, 8'hFD},
            '{8'h22, 8'h40, 8'h00, 8'h04, 8'h03, 16'hFF40, 16'h01FE, 8'h02, 8'h04, 8'hFD},
            '{8'h02, 8'h12, 8'h00, 8'h06, 8'h03, 16'h5678, 16'h01FE, 8'h02, 8'h04, 8'hFD}
        };
        hand = '{8'hA9, 8'h07, 8'hA2, 8'h30, 8'h32, 8'hA9, 8'hC3, 8'h09, 8'h0C,
                 8'h12, 8'h4A, 8'h62, 8'h10};
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(pc, 16'h0000);
        chk({p, s}, 16'h04FF);
        chk({13'h0000, fetching, mem_re, mem_we}, 16'h0006);
        $display("reset test done");
        // Every opcode and addressing form except 4A, 62, 12 and 32, each from a clean reset
        foreach (rows[r]) begin
            prep();
            mem[16'h0000] = rows[r].op;
            mem[16'h0001] = rows[r].b1;
            mem[16'h0002] = rows[r].b2;
            run(1);
            got = rows[r].sel == 8'h00 ? {8'h00, a} : rows[r].sel == 8'h01 ? {8'h00, x}
                : rows[r].sel == 8'h02 ? {8'h00, y} : pc;
            chk(got, rows[r].v);
            chk({8'h00, mem[rows[r].ma]}, {8'h00, rows[r].mv});
            chk({p, s}, {rows[r].pv, rows[r].sv});
            chk(cyc[15:0], {8'h00, rows[r].n});
            $display("row %0d test done", r);
        end
        // X mode load and OR, mode clear, shift of A, then multiply via zz+X
        prep();
        foreach (hand[i]) mem[i] = hand[i];
        run(8);
        chk({8'h00, mem[16'h0030]}, 16'h00CF);
        chk({8'h00, a}, 16'h00B0);
        chk({8'h00, mem[16'h01FF]}, 16'h0001);
        chk({p, s}, 16'h05FE);
        chk(pc, 16'h000D);
        chk(cyc[15:0], 16'h0022);
        $display("index mode test done");
        results();
    end
endmodule : cpu_jump_load_logic_ops_bench
`default_nettype wire
